/* File: rtl/pbf_pkg.sv */
// Constants for the port B pin function select block
package pbf_pkg;

  localparam int unsigned PIN_COUNT = 16;
  localparam int unsigned REG_WIDTH = 16;
  localparam int unsigned BUS_ADDR_WIDTH = 4;
  localparam int unsigned BUS_DATA_WIDTH = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [3:0] OFS_HIGH_PIN_FUNCTION = 4'h0;
  localparam logic [3:0] OFS_LOW_PIN_FUNCTION = 4'h4;
  localparam logic [3:0] OFS_PORT_DIRECTION = 4'h8;
  localparam logic [3:0] OFS_PORT_DATA = 4'hC;

  // Reset values, applied by power-on reset only
  localparam logic [15:0] RST_PIN_FUNCTION = 16'h0000;
  localparam logic [15:0] RST_PORT_DIRECTION = 16'h0000;
  localparam logic [15:0] RST_PORT_DATA = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Two-bit function codes
  typedef enum logic [1:0] {
    FN_GPIO = 2'h0,
    FN_ALT_ONE = 2'h1,
    FN_ALT_TWO = 2'h2,
    FN_PATTERN = 2'h3
  } pbf_func_e;

  // Pin positions of the multiplexed peripheral lines
  localparam int unsigned PIN_IRQ_BASE = 12;
  localparam int unsigned PIN_SER0_CLOCK = 12;
  localparam int unsigned PIN_SER1_CLOCK = 13;
  localparam int unsigned PIN_SER1_TX = 11;
  localparam int unsigned PIN_SER1_RX = 10;
  localparam int unsigned PIN_SER0_TX = 9;
  localparam int unsigned PIN_SER0_RX = 8;
  localparam int unsigned PIN_TIMER_D = 7;
  localparam int unsigned PIN_TIMER_C = 6;
  localparam int unsigned PIN_CAPCOMP_TOP = 5;

  // Levels seen by a peripheral input while its pin is routed elsewhere
  localparam logic IDLE_IRQ = 1'b1;
  localparam logic IDLE_RX = 1'b1;
  localparam logic IDLE_SER_CLOCK = 1'b1;
  localparam logic IDLE_TIMER_CLOCK = 1'b0;
  localparam logic IDLE_CAPCOMP = 1'b0;

endpackage : pbf_pkg

/* File: rtl/pbf_pin_function_select.sv */
// Port B pin function select: registers, pin multiplexer and peripheral routing
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.

////////////////////////////////////////////////////////////////////////////////
module pbf_pin_function_select #(
  parameter int unsigned PINS = pbf_pkg::PIN_COUNT
) (
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [pbf_pkg::BUS_ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pbf_pkg::BUS_DATA_WIDTH-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [pbf_pkg::BUS_DATA_WIDTH-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Package pins
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  // Interrupt controller: ext_interrupt_in_7 down to ext_interrupt_in_4
  output logic [3:0] ext_interrupt_in,
  // Serial channels, index 1 and 0
  input wire logic [1:0] serial_clock_line_out,
  output logic [1:0] serial_clock_line_in,
  input wire logic [1:0] serial_transmit_out,
  output logic [1:0] serial_receive_in,
  // Timer
  output logic timer_ext_clock_d,
  output logic timer_ext_clock_c,
  input wire logic timer4_compl_compare_b,
  input wire logic timer4_compl_compare_a,
  input wire logic [5:0] timer_capcomp_out,
  output logic [5:0] timer_capcomp_in,
  // Timing pattern unit
  input wire logic [PINS-1:0] pattern_out,
  input wire logic [PINS-1:0] pattern_next_data_enable
);

  if (PINS != pbf_pkg::PIN_COUNT) begin : g_bad_pins
    $error("pbf_pin_function_select serves exactly sixteen pins");
  end
  // Registers, offsets and read data are laid out for these widths only
  if (pbf_pkg::REG_WIDTH != PINS) begin : g_bad_reg_width
    $error("pbf_pin_function_select needs registers of one bit per pin");
  end
  if (pbf_pkg::BUS_ADDR_WIDTH != $bits(pbf_pkg::OFS_PORT_DATA)) begin : g_bad_addr_width
    $error("pbf_pin_function_select needs offsets as wide as the address");
  end
  if (pbf_pkg::BUS_DATA_WIDTH != 2 * pbf_pkg::REG_WIDTH) begin : g_bad_data_width
    $error("pbf_pin_function_select needs a bus twice the register width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] high_pin_function_reg_q;
  logic [15:0] low_pin_function_reg_q;
  logic [15:0] port_direction_reg_q;
  logic [15:0] port_data_reg_q;
  logic [31:0] all_codes;

  // Pin 15 code sits in the top two bits of the high register
  assign all_codes = {high_pin_function_reg_q, low_pin_function_reg_q};

  function automatic pbf_pkg::pbf_func_e code_of(input logic [31:0] codes, input int unsigned pin);
    code_of = pbf_pkg::pbf_func_e'(codes[2*pin +: 2]);
  endfunction : code_of

  // Byte lanes two and three carry nothing here
  function automatic logic [15:0] merge_bytes(input logic [15:0] old_val,
                                              input logic [15:0] new_val,
                                              input logic [1:0] lanes,
                                              input logic [15:0] keep);
    logic [15:0] m;
    m = {{8{lanes[1]}}, {8{lanes[0]}}} & ~keep;
    merge_bytes = (old_val & ~m) | (new_val & m);
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: every access takes exactly two cycles
  // The wait cycle lets read data come from a flop, not the address decode
  logic ack_q;
  logic bus_req;
  logic wr_fire;
  logic [pbf_pkg::BUS_DATA_WIDTH-1:0] readdata_q;
  logic [15:0] wr_half;

  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign wr_fire = avs_write & ack_q;
  assign wr_half = avs_writedata[15:0];
  assign avs_readdata = readdata_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser: three stages, accepted when the last two agree
  // A pulse of a single cycle never reaches pin_state_q
  logic [PINS-1:0] pin_s1_q;
  logic [PINS-1:0] pin_s2_q;
  logic [PINS-1:0] pin_s3_q;
  logic [PINS-1:0] pin_state_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_state_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < PINS; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_state_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function select registers
  // Only rst clears them; a manual reset or low-power mode must not reach here
  // Reserved codes are stored as written; only the decode below ignores them
  always_ff @(posedge clock) begin
    if (rst) begin
      high_pin_function_reg_q <= pbf_pkg::RST_PIN_FUNCTION;
      low_pin_function_reg_q <= pbf_pkg::RST_PIN_FUNCTION;
    end else if (wr_fire) begin
      if (avs_address == pbf_pkg::OFS_HIGH_PIN_FUNCTION) begin
        high_pin_function_reg_q <= merge_bytes(high_pin_function_reg_q, wr_half,
                                               avs_byteenable[1:0], '0);
      end
      if (avs_address == pbf_pkg::OFS_LOW_PIN_FUNCTION) begin
        low_pin_function_reg_q <= merge_bytes(low_pin_function_reg_q, wr_half,
                                              avs_byteenable[1:0], '0);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      port_direction_reg_q <= pbf_pkg::RST_PORT_DIRECTION;
    end else if (wr_fire && avs_address == pbf_pkg::OFS_PORT_DIRECTION) begin
      port_direction_reg_q <= merge_bytes(port_direction_reg_q, wr_half,
                                          avs_byteenable[1:0], '0);
    end
  end

  // Pattern pins with next-data enabled are write-protected bit by bit
  logic [PINS-1:0] data_locked;

  always_comb begin
    data_locked = '0;
    for (int i = 0; i < PINS; i++) begin
      data_locked[i] = (code_of(all_codes, i) == pbf_pkg::FN_PATTERN)
                       & pattern_next_data_enable[i];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      port_data_reg_q <= pbf_pkg::RST_PORT_DATA;
    end else if (wr_fire && avs_address == pbf_pkg::OFS_PORT_DATA) begin
      port_data_reg_q <= merge_bytes(port_data_reg_q, wr_half,
                                     avs_byteenable[1:0], data_locked);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, sampled in the first cycle so data stands with the answer
  logic [15:0] data_view;
  logic [15:0] read_half;

  // Output pins read the register, input pins read the pin
  // This holds whatever function the pin has; only direction decides
  assign data_view = (port_direction_reg_q & port_data_reg_q)
                     | (~port_direction_reg_q & pin_state_q);

  always_comb begin
    unique case (avs_address)
      pbf_pkg::OFS_HIGH_PIN_FUNCTION: read_half = high_pin_function_reg_q;
      pbf_pkg::OFS_LOW_PIN_FUNCTION: read_half = low_pin_function_reg_q;
      pbf_pkg::OFS_PORT_DIRECTION: read_half = port_direction_reg_q;
      pbf_pkg::OFS_PORT_DATA: read_half = data_view;
      default: read_half = '0;
    endcase
  end

  // Upper half reads zero; the registers are sixteen bits wide
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata_q <= '0;
    end else if (avs_read && !ack_q) begin
      readdata_q <= {16'h0000, read_half};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin output multiplexer
  logic [PINS-1:0] out_d;
  logic [PINS-1:0] oe_d;
  logic [PINS-1:0] ser_clock_at_pin;
  logic [PINS-1:0] capcomp_at_pin;

  // Narrow peripheral vectors spread to pin positions, so the per-pin loop
  // below never indexes past the end of a vector
  assign ser_clock_at_pin = PINS'(serial_clock_line_out) << pbf_pkg::PIN_SER0_CLOCK;
  assign capcomp_at_pin = PINS'(timer_capcomp_out);

  always_comb begin
    out_d = '0;
    oe_d = '0;
    for (int i = 0; i < PINS; i++) begin
      unique case (code_of(all_codes, i))
        pbf_pkg::FN_GPIO: begin
          out_d[i] = port_data_reg_q[i];
          oe_d[i] = port_direction_reg_q[i];
        end
        pbf_pkg::FN_ALT_ONE: begin
          // Interrupt and timer clock pins are inputs; other pins are reserved
          out_d[i] = 1'b0;
          oe_d[i] = 1'b0;
        end
        pbf_pkg::FN_ALT_TWO: begin
          if (i == pbf_pkg::PIN_SER1_CLOCK || i == pbf_pkg::PIN_SER0_CLOCK) begin
            out_d[i] = ser_clock_at_pin[i];
            oe_d[i] = port_direction_reg_q[i];
          end else if (i == pbf_pkg::PIN_SER1_TX) begin
            out_d[i] = serial_transmit_out[1];
            oe_d[i] = 1'b1;
          end else if (i == pbf_pkg::PIN_SER0_TX) begin
            out_d[i] = serial_transmit_out[0];
            oe_d[i] = 1'b1;
          end else if (i == pbf_pkg::PIN_TIMER_D) begin
            out_d[i] = timer4_compl_compare_b;
            oe_d[i] = 1'b1;
          end else if (i == pbf_pkg::PIN_TIMER_C) begin
            out_d[i] = timer4_compl_compare_a;
            oe_d[i] = 1'b1;
          end else if (i <= pbf_pkg::PIN_CAPCOMP_TOP) begin
            out_d[i] = capcomp_at_pin[i];
            oe_d[i] = port_direction_reg_q[i];
          end else begin
            // Receive pins and the reserved pins 15, 14 stay inputs
            out_d[i] = 1'b0;
            oe_d[i] = 1'b0;
          end
        end
        pbf_pkg::FN_PATTERN: begin
          out_d[i] = pattern_out[i];
          oe_d[i] = 1'b1;
        end
      endcase
    end
  end

  // Registered so a code change never glitches a pin within a cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= out_d;
      pin_oe <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral inputs, parked at an idle level when their pin is elsewhere
  localparam int unsigned IRQ_LINES = $bits(ext_interrupt_in);
  localparam int unsigned SER_CHANNELS = $bits(serial_receive_in);
  localparam int unsigned CAPCOMP_LINES = $bits(timer_capcomp_in);

  function automatic logic route_in(input logic [31:0] codes, input int unsigned pin,
                                    input pbf_pkg::pbf_func_e want,
                                    input logic [15:0] state, input logic idle);
    route_in = (code_of(codes, pin) == want) ? state[pin] : idle;
  endfunction : route_in

  always_ff @(posedge clock) begin
    if (rst) begin
      ext_interrupt_in <= {IRQ_LINES{pbf_pkg::IDLE_IRQ}};
      serial_clock_line_in <= {SER_CHANNELS{pbf_pkg::IDLE_SER_CLOCK}};
      serial_receive_in <= {SER_CHANNELS{pbf_pkg::IDLE_RX}};
      timer_ext_clock_d <= pbf_pkg::IDLE_TIMER_CLOCK;
      timer_ext_clock_c <= pbf_pkg::IDLE_TIMER_CLOCK;
      timer_capcomp_in <= {CAPCOMP_LINES{pbf_pkg::IDLE_CAPCOMP}};
    end else begin
      for (int k = 0; k < IRQ_LINES; k++) begin
        ext_interrupt_in[k] <= route_in(all_codes, pbf_pkg::PIN_IRQ_BASE + k,
                                        pbf_pkg::FN_ALT_ONE, pin_state_q,
                                        pbf_pkg::IDLE_IRQ);
      end
      serial_clock_line_in[1] <= route_in(all_codes, pbf_pkg::PIN_SER1_CLOCK,
                                          pbf_pkg::FN_ALT_TWO, pin_state_q,
                                          pbf_pkg::IDLE_SER_CLOCK);
      serial_clock_line_in[0] <= route_in(all_codes, pbf_pkg::PIN_SER0_CLOCK,
                                          pbf_pkg::FN_ALT_TWO, pin_state_q,
                                          pbf_pkg::IDLE_SER_CLOCK);
      serial_receive_in[1] <= route_in(all_codes, pbf_pkg::PIN_SER1_RX,
                                       pbf_pkg::FN_ALT_TWO, pin_state_q,
                                       pbf_pkg::IDLE_RX);
      serial_receive_in[0] <= route_in(all_codes, pbf_pkg::PIN_SER0_RX,
                                       pbf_pkg::FN_ALT_TWO, pin_state_q,
                                       pbf_pkg::IDLE_RX);
      timer_ext_clock_d <= route_in(all_codes, pbf_pkg::PIN_TIMER_D,
                                    pbf_pkg::FN_ALT_ONE, pin_state_q,
                                    pbf_pkg::IDLE_TIMER_CLOCK);
      timer_ext_clock_c <= route_in(all_codes, pbf_pkg::PIN_TIMER_C,
                                    pbf_pkg::FN_ALT_ONE, pin_state_q,
                                    pbf_pkg::IDLE_TIMER_CLOCK);
      for (int k = 0; k <= pbf_pkg::PIN_CAPCOMP_TOP; k++) begin
        timer_capcomp_in[k] <= route_in(all_codes, k, pbf_pkg::FN_ALT_TWO,
                                        pin_state_q, pbf_pkg::IDLE_CAPCOMP);
      end
    end
  end

endmodule : pbf_pin_function_select

/* File: verification/pbf_monitor.sv */
// Checker for the pin function select block, bound to its top module
module pbf_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [3:0] ext_interrupt_in,
  input wire logic [1:0] serial_transmit_out,
  input wire logic [1:0] serial_receive_in,
  input wire logic timer4_compl_compare_b,
  input wire logic [15:0] pattern_out
);
  // Shadow registers, updated at the completing edge like the block's own
  logic [31:0] fn_q;
  logic [15:0] dir_q;
  logic [15:0] be_m;
  logic [15:0] wd;
  assign be_m = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd = avs_writedata[15:0] & be_m;
  always_ff @(posedge clock) begin
    if (rst) begin
      fn_q <= 32'h0000_0000;
      dir_q <= 16'h0000;
    end else if (avs_write && !avs_waitrequest) begin
      case (avs_address)
        pbf_pkg::OFS_HIGH_PIN_FUNCTION: fn_q[31:16] <= fn_q[31:16] & ~be_m | wd;
        pbf_pkg::OFS_LOW_PIN_FUNCTION: fn_q[15:0] <= fn_q[15:0] & ~be_m | wd;
        pbf_pkg::OFS_PORT_DIRECTION: dir_q <= dir_q & ~be_m | wd;
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access did not finish after one wait cycle");
  for (genvar n = 0; n < 16; n++) begin : g_pin
    pattern_drive_a: assert property ($past(fn_q[2*n +: 2]) == 2'h3 |-> pin_oe[n] && pin_out[n] == $past(pattern_out[n]))
      else $error("pattern code does not drive the pin");
    gpio_dir_a: assert property ($past(fn_q[2*n +: 2]) == 2'h0 |-> pin_oe[n] == $past(dir_q[n]))
      else $error("general I/O enable differs from direction");
  end
  tx_drive_a: assert property ($past(fn_q[23:22]) == 2'h2 |-> pin_oe[11] && pin_out[11] == $past(serial_transmit_out[1]))
    else $error("transmit data not on pin 11");
  rx_input_a: assert property ($past(fn_q[21:20]) == 2'h2 |-> !pin_oe[10])
    else $error("receive pin is driven");
  rx_idle_a: assert property ($past(fn_q[17:16]) != 2'h2 |-> serial_receive_in[0])
    else $error("receive input not idle while unrouted");
  compare_a: assert property ($past(fn_q[15:14]) == 2'h2 |-> pin_oe[7] && pin_out[7] == $past(timer4_compl_compare_b))
    else $error("compare output not on pin 7");
  irq_idle_a: assert property ($past(fn_q[31:30]) != 2'h1 |-> ext_interrupt_in[3])
    else $error("interrupt input not idle while unrouted");
  reserved_off_a: assert property ($past(fn_q[29:28]) == 2'h2 |-> !pin_oe[14])
    else $error("reserved code drives pin 14");
endmodule : pbf_monitor

bind pbf_pin_function_select pbf_monitor pbf_monitor_inst (.clock, .rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .pin_out,
  .pin_oe, .ext_interrupt_in, .serial_transmit_out, .serial_receive_in,
  .timer4_compl_compare_b, .pattern_out);

/* File: verification/pbf_periph_model.sv */
// Peripheral stand-in whose data outputs come from a counter that steps every cycle so stale routing shows
module pbf_periph_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] lock_en,
  output logic [1:0] serial_clock_line_out,
  output logic [1:0] serial_transmit_out,
  output logic timer4_compl_compare_b,
  output logic timer4_compl_compare_a,
  output logic [5:0] timer_capcomp_out,
  output logic [15:0] pattern_out,
  output logic [15:0] pattern_next_data_enable
);
  logic [15:0] cnt_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h9E37;
    end
  end
  assign pattern_out = cnt_q;
  assign serial_clock_line_out = cnt_q[3:2];
  assign serial_transmit_out = ~cnt_q[1:0];
  assign {timer4_compl_compare_b, timer4_compl_compare_a} = cnt_q[5:4];
  assign timer_capcomp_out = cnt_q[11:6] ^ cnt_q[5:0];
  assign pattern_next_data_enable = lock_en;
endmodule : pbf_periph_model

/* File: verification/pbf_pin_function_select_test.sv */
// Self-checking bench for the pin function select block
module pbf_pin_function_select_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable, ext_interrupt_in;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] pin_in, pin_out, pin_oe, pattern_out, pattern_next_data_enable, ext_q, lock_en, e;
  logic [1:0] serial_clock_line_out, serial_clock_line_in, serial_transmit_out, serial_receive_in;
  logic timer_ext_clock_d, timer_ext_clock_c, timer4_compl_compare_b, timer4_compl_compare_a;
  logic [5:0] timer_capcomp_out, timer_capcomp_in;
  int failures = 0;
  int cmp_count = 0;
  // Pin level: the block wins where it drives, else the outside world
  assign pin_in = pin_oe & pin_out | ~pin_oe & ext_q;
  pbf_pin_function_select pbf_pin_function_select_inst (.clock, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in,
    .pin_out, .pin_oe, .ext_interrupt_in, .serial_clock_line_out, .serial_clock_line_in,
    .serial_transmit_out, .serial_receive_in, .timer_ext_clock_d, .timer_ext_clock_c,
    .timer4_compl_compare_b, .timer4_compl_compare_a, .timer_capcomp_out, .timer_capcomp_in,
    .pattern_out, .pattern_next_data_enable);
  pbf_periph_model pbf_periph_model_inst (.clock, .rst, .lock_en, .serial_clock_line_out,
    .serial_transmit_out, .timer4_compl_compare_b, .timer4_compl_compare_a,
    .timer_capcomp_out, .pattern_out, .pattern_next_data_enable);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Upper data half is set to ones: the block must ignore it
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'hFFFF, d};
    avs_byteenable <= be;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000, 4'hF);
    chk(q, {16'h0000, exp});
  endtask : rd
  task automatic t_regs();
    rd(4'h0, 16'h0000);
    rd(4'h4, 16'h0000);
    bus(1'b1, 4'h0, 16'hFFFF, 4'h2);
    rd(4'h0, 16'hFF00);
    rd(4'h4, 16'h0000);
    bus(1'b1, 4'h6, 16'hFFFF, 4'hF);
    rd(4'h6, 16'h0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_pattern();
    lock_en <= 16'h00FF;
    bus(1'b1, 4'h0, 16'hFFFF, 4'hF);
    bus(1'b1, 4'h4, 16'hFFFF, 4'hF);
    e = pattern_out;
    @(posedge clock);
    chk(pin_out, e);
    chk(pin_oe, 16'hFFFF);
    bus(1'b1, 4'hC, 16'hFFFF, 4'hF);
    lock_en <= 16'h0000;
    bus(1'b1, 4'h0, 16'h0000, 4'hF);
    bus(1'b1, 4'h4, 16'h0000, 4'hF);
    bus(1'b1, 4'h8, 16'hFFFF, 4'hF);
    rd(4'hC, 16'hFF00);
    chk(pin_out, 16'hFF00);
    chk(pin_oe, 16'hFFFF);
    $display("test pattern done");
  endtask : t_pattern
  task automatic t_inputs();
    bus(1'b1, 4'h8, 16'h0000, 4'hF);
    bus(1'b1, 4'h0, 16'h55AA, 4'hF);
    bus(1'b1, 4'h4, 16'h5AAA, 4'hF);
    for (int i = 0; i < 2; i++) begin
      ext_q <= (i == 0) ? 16'hA5C3 : 16'h5A3C;
      repeat (6) @(posedge clock);
      chk(ext_interrupt_in, ext_q[15:12]);
      chk(serial_receive_in, {ext_q[10], ext_q[8]});
      chk({timer_ext_clock_d, timer_ext_clock_c}, ext_q[7:6]);
      chk(timer_capcomp_in, ext_q[5:0]);
      chk(pin_oe, 16'h0A00);
    end
    bus(1'b1, 4'h0, 16'h0AAA, 4'hF);
    repeat (2) @(posedge clock);
    chk(serial_clock_line_in, {ext_q[13], ext_q[12]});
    chk(pin_oe[13:12], 2'h0);
    $display("test inputs done");
  endtask : t_inputs
  task automatic t_outputs();
    bus(1'b1, 4'h8, 16'hFFFF, 4'hF);
    bus(1'b1, 4'h0, 16'h0AAA, 4'hF);
    bus(1'b1, 4'h4, 16'hAAAA, 4'hF);
    e = {2'h0, serial_clock_line_out, serial_transmit_out[1], 1'b0, serial_transmit_out[0], 1'b0,
      timer4_compl_compare_b, timer4_compl_compare_a, timer_capcomp_out};
    @(posedge clock);
    chk(pin_out & 16'h3AFF, e);
    chk(pin_oe, 16'hFAFF);
    $display("test outputs done");
  endtask : t_outputs
  task automatic t_reserved();
    bus(1'b1, 4'h0, 16'h2040, 4'hF);
    rd(4'h0, 16'h2040);
    chk(pin_oe[15:11], 5'h16);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(4'h0, 16'h0000);
    rd(4'h8, 16'h0000);
    $display("test reserved and reset done");
  endtask : t_reserved
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    ext_q = 16'h0000;
    lock_en = 16'h0000;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_pattern();
    t_inputs();
    t_outputs();
    t_reserved();
    end_sim();
  end
endmodule : pbf_pin_function_select_test
